//--- inc/kwdt_pkg.sv
// Shared constants of the keyed watchdog timer.
package kwdt_pkg;
    // Register byte offsets on the bus.
    localparam logic [3:0] KWDT_OFS_MODE = 4'h0;
    localparam logic [3:0] KWDT_OFS_CLOCK = 4'h4;
    localparam logic [3:0] KWDT_OFS_RESTART = 4'h8;
    localparam logic [3:0] KWDT_OFS_STATUS = 4'hC;
    localparam logic [3:0] KWDT_OFS_IRQ_STATUS = 4'h0;
    localparam logic [7:0] KWDT_OFS_IRQ_STAT_FULL = 8'h10;
    localparam logic [7:0] KWDT_OFS_IRQ_MASK = 8'h14;
    // Mode register field positions.
    localparam int KWDT_MODE_ON_BIT = 0;
    localparam int KWDT_MODE_RST_BIT = 1;
    localparam int KWDT_MODE_IRQ_BIT = 2;
    localparam int KWDT_MODE_PIN_BIT = 3;
    localparam logic [11:0] KWDT_MODE_KEY = 12'h234;
    // Clock register field values.
    localparam logic [8:0] KWDT_CLOCK_KEY = 9'h06E;
    // Restart key.
    localparam logic [15:0] KWDT_RESTART_KEY = 16'hC071;
    // Low part of the preload value.
    localparam logic [11:0] KWDT_PRELOAD_LOW = 12'hFFF;
    // Reset values of the mode and clock fields.
    localparam logic [3:0] KWDT_MODE_RESET = 4'h0;
    localparam logic [5:0] KWDT_CLOCK_RESET = 6'h00;
    // Prescaler taps for each clock select code.
    localparam int KWDT_DIV8_BIT = 2;
    localparam int KWDT_DIV32_BIT = 4;
    localparam int KWDT_DIV128_BIT = 6;
    localparam int KWDT_DIV1024_BIT = 9;
    // Overflow pin low time in master clock cycles.
    localparam logic [3:0] KWDT_PIN_CYCLES = 4'h8;
    // Sticky interrupt status layout: bit 0 overflow.
    localparam int KWDT_IRQ_BITS = 1;
endpackage

//--- verilog/kwdt_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
// Free running divider of the master clock with one tick per selected period.
module kwdt_prescaler
    import kwdt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic clear_i,
    input wire logic [1:0] select_i,
    output logic tick_o
);
    // Divider count; a tap of it wraps at each division period.
    logic [9:0] div_q;
    // Selected tap is all ones just before wrap.
    logic [9:0] mask;

    // Pick how many low bits must be all ones for the tick.
    always_comb begin
        case (select_i)
            2'h0: mask = 10'h007;
            2'h1: mask = 10'h01F;
            2'h2: mask = 10'h07F;
            default: mask = 10'h3FF;
        endcase
    end

    // Count master clocks; a restart realigns the divider.
    always_ff @(posedge clk_i) begin
        if (rst_i || (ce_i && clear_i)) begin
            div_q <= 10'h000;
        end else if (ce_i) begin
            div_q <= div_q + 10'h001;
        end
    end

    // The tick is high one cycle in every selected period.
    assign tick_o = ce_i && ((div_q & mask) == mask);
endmodule
`default_nettype wire

//--- verilog/kwdt_pulse.sv
`timescale 1ns/1ps
`default_nettype none
// Holds an active-low output for a fixed number of cycles after a start.
module kwdt_pulse
    import kwdt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic start_i,
    output logic pin_n_o
);
    // Cycles left with the pin low.
    logic [3:0] left_q;

    // Load on start, then count down to zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            left_q <= 4'h0;
            pin_n_o <= 1'b1;
        end else if (ce_i) begin
            if (start_i) begin
                left_q <= KWDT_PIN_CYCLES - 4'h1;
                pin_n_o <= 1'b0;
            end else if (left_q != 4'h0) begin
                left_q <= left_q - 4'h1;
            end else begin
                pin_n_o <= 1'b1;
            end
        end
    end

    // The pin stays low exactly eight cycles after the start.
    pin_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(pin_n_o) && ce_i |-> !pin_n_o [*8] ##1 (pin_n_o || !ce_i || $past(start_i)))
        else $error("overflow pin low time wrong");
endmodule
`default_nettype wire

//--- verilog/kwdt_top.sv
// How it works
// - Enabled overflow raises internal system reset.
// - Enabled overflow sends one interrupt pulse.
// - Enabled overflow drives pin low eight cycles.
// - Sixteen-bit down counter; passing zero overflows.
// - Restart loads FFF plus high preload bits.
// - Clock select picks divide 8/32/128/1024.
// - Mode writes need key in same access.
// - Mode key 0x234; key reads zero.
// - Clock key 0x06E; key reads zero.
// - Disabled watchdog produces no overflow outputs.
// - Reset leaves watchdog off, registers zero.
// - Restart key 0xC071 restarts; others ignored.
// - Status flag set on overflow, cleared restart.
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module kwdt_top
    import kwdt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic watchdog_irq_pulse_o,
    output logic system_reset_o,
    output logic overflow_pin_n_o,
    output logic irq_o
);
    import kwdt_pkg::*;

    // Mode fields: enable, reset enable, interrupt enable, pin enable.
    logic watchdog_on_q;
    logic overflow_reset_on_q;
    logic overflow_irq_on_q;
    logic overflow_pin_on_q;
    // Clock fields.
    logic [1:0] count_clock_select_q;
    logic [3:0] high_preload_value_q;
    // Watchdog counter and its overflow flag.
    logic [15:0] count_q;
    logic overflow_flag_q;
    // Sticky interrupt status and its mask.
    logic irq_stat_q;
    logic irq_mask_q;
    // Bus decode.
    logic bus_req;
    logic wr_go;
    logic rd_go;
    logic word_wr;
    logic mode_wr;
    logic clock_wr;
    logic restart;
    logic tick;
    logic overflow;
    logic [31:0] rd_d;

    // A request is answered once; ack drops the cycle after it is given.
    // Masking with ack keeps a strobe that is still held from being taken a second time.
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_go = bus_req && wb_we_i && ce_i;
    assign rd_go = bus_req && !wb_we_i && ce_i;
    // The mode and clock registers accept only full-word writes so key and fields come together.
    // A partial write could otherwise pair a stale key byte with fresh field bits.
    assign word_wr = wr_go && (wb_sel_i == 4'hF);
    // Mode write needs its key in the same access.
    assign mode_wr = word_wr && (wb_adr_i == {4'h0, KWDT_OFS_MODE}) && (wb_dat_i[15:4] == KWDT_MODE_KEY);
    // Clock write needs its key in the same access.
    assign clock_wr = word_wr && (wb_adr_i == {4'h0, KWDT_OFS_CLOCK}) && (wb_dat_i[15:7] == KWDT_CLOCK_KEY);
    // Only the restart key in the low half word restarts; upper bits are ignored.
    // A runaway store of random data is unlikely to hit the full sixteen-bit key.
    assign restart = wr_go && (wb_adr_i == {4'h0, KWDT_OFS_RESTART}) && wb_sel_i[1:0] == 2'h3
        && (wb_dat_i[15:0] == KWDT_RESTART_KEY);

    // Divided master clock drives the counter decrement.
    // A restart clears it, so the first tick after a reload is a full period away.
    kwdt_prescaler u_prescaler (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .clear_i(restart),
        .select_i(count_clock_select_q),
        .tick_o(tick)
    );

    // Counter passes zero on a tick while enabled.
    // A restart in the same cycle wins, so a late but valid restart still saves the system.
    // The count only moves while enabled, so a disabled block never reaches this.
    assign overflow = watchdog_on_q && tick && (count_q == 16'h0000) && !restart;

    // Mode register.
    // Without the key the write is dropped whole; no field can change on its own.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {overflow_pin_on_q, overflow_irq_on_q, overflow_reset_on_q, watchdog_on_q} <= KWDT_MODE_RESET;
        end else if (mode_wr) begin
            watchdog_on_q <= wb_dat_i[KWDT_MODE_ON_BIT];
            overflow_reset_on_q <= wb_dat_i[KWDT_MODE_RST_BIT];
            overflow_irq_on_q <= wb_dat_i[KWDT_MODE_IRQ_BIT];
            overflow_pin_on_q <= wb_dat_i[KWDT_MODE_PIN_BIT];
        end
    end

    // Clock register.
    // Select and preload share one key, so both change in the same write.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {high_preload_value_q, count_clock_select_q} <= KWDT_CLOCK_RESET;
        end else if (clock_wr) begin
            count_clock_select_q <= wb_dat_i[1:0];
            high_preload_value_q <= wb_dat_i[5:2];
        end
    end

    // Down counter: restart loads preload, each tick while enabled decrements, wraps past zero.
    // Reset loads the low preload, so an enable without a restart still has a full low part.
    // After an overflow the count wraps to all ones and keeps going until restarted.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_q <= {4'h0, KWDT_PRELOAD_LOW};
        end else if (restart) begin
            count_q <= {high_preload_value_q, KWDT_PRELOAD_LOW};
        end else if (tick && watchdog_on_q) begin
            count_q <= count_q - 16'h0001;
        end
    end

    // Overflow flag: set wins over a restart in the same cycle.
    // The overflow term already excludes a restart, so the two never meet here.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overflow_flag_q <= 1'b0;
        end else if (overflow) begin
            overflow_flag_q <= 1'b1;
        end else if (restart) begin
            overflow_flag_q <= 1'b0;
        end
    end

    // Interrupt pulse and internal reset request, one cycle each.
    // Both come from flip-flops one cycle after the overflow cycle.
    // A low clock enable stretches them along with the rest of the block.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            watchdog_irq_pulse_o <= 1'b0;
            system_reset_o <= 1'b0;
        end else if (ce_i) begin
            watchdog_irq_pulse_o <= overflow && overflow_irq_on_q;
            system_reset_o <= overflow && overflow_reset_on_q;
        end
    end

    // External pin pulse generator.
    // A second overflow while the pin is low starts the eight cycles again.
    kwdt_pulse u_pulse (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .start_i(overflow && overflow_pin_on_q),
        .pin_n_o(overflow_pin_n_o)
    );

    // Sticky status: an overflow beats the clear-on-read of the same cycle.
    // Losing an overflow to a racing read would hide the event from software.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= 1'b0;
        end else if (overflow) begin
            irq_stat_q <= 1'b1;
        end else if (rd_go && wb_adr_i == KWDT_OFS_IRQ_STAT_FULL) begin
            irq_stat_q <= 1'b0;
        end
    end

    // Interrupt mask register.
    // Only byte lane zero carries the single mask bit.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_q <= 1'b0;
        end else if (wr_go && wb_adr_i == KWDT_OFS_IRQ_MASK && wb_sel_i[0]) begin
            irq_mask_q <= wb_dat_i[0];
        end
    end

    // Level interrupt from a flip-flop.
    // Registering the level costs one cycle but keeps the output free of glitches.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_o <= irq_stat_q && irq_mask_q;
        end
    end

    // Read mux; keys read as zero and unmapped addresses read zero.
    // Every register uses only its low bits, so the upper bits are constant zero.
    always_comb begin
        rd_d = 32'h0000_0000;
        case (wb_adr_i)
            {4'h0, KWDT_OFS_MODE}: rd_d[3:0] = {overflow_pin_on_q, overflow_irq_on_q,
                overflow_reset_on_q, watchdog_on_q};
            {4'h0, KWDT_OFS_CLOCK}: rd_d[5:0] = {high_preload_value_q, count_clock_select_q};
            {4'h0, KWDT_OFS_STATUS}: rd_d[0] = overflow_flag_q;
            KWDT_OFS_IRQ_STAT_FULL: rd_d[0] = irq_stat_q;
            KWDT_OFS_IRQ_MASK: rd_d[0] = irq_mask_q;
            default: rd_d = 32'h0000_0000;
        endcase
    end

    // Ack one cycle after the request; every address is answered.
    // Read data is zero outside ack, so slave outputs can be ORed without gating.
    // A low clock enable holds ack, so a frozen block simply stretches the cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= bus_req;
            wb_dat_o <= rd_go ? rd_d : 32'h0000_0000;
        end
    end

    // A wrong mode key leaves the enable field unchanged.
    mode_key_a: assert property (@(posedge clk_i) disable iff (rst_i)
        word_wr && wb_adr_i == {4'h0, KWDT_OFS_MODE} && wb_dat_i[15:4] != KWDT_MODE_KEY |=> $stable(watchdog_on_q))
        else $error("mode changed without key");
    // A wrong clock key leaves the high preload field unchanged.
    clock_key_a: assert property (@(posedge clk_i) disable iff (rst_i)
        word_wr && wb_adr_i == {4'h0, KWDT_OFS_CLOCK} && wb_dat_i[15:7] != KWDT_CLOCK_KEY
        |=> $stable(high_preload_value_q))
        else $error("clock changed without key");
    // Restart loads FFF and the preload bits.
    restart_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
        restart |=> count_q == {$past(high_preload_value_q), KWDT_PRELOAD_LOW})
        else $error("restart load wrong");
    // Interrupt pulse lasts a single cycle.
    irq_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
        watchdog_irq_pulse_o && ce_i |=> !watchdog_irq_pulse_o)
        else $error("interrupt pulse too long");
    // Interrupt follows overflow only when enabled.
    irq_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(watchdog_irq_pulse_o) |-> $past(overflow && overflow_irq_on_q))
        else $error("interrupt without cause");
    // Internal reset follows an enabled overflow.
    reset_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && overflow && overflow_reset_on_q |=> system_reset_o)
        else $error("missing internal reset");
    // Disabled watchdog raises no interrupt pulse and no internal reset.
    disabled_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !watchdog_on_q |=> !watchdog_irq_pulse_o && !system_reset_o)
        else $error("output while disabled");
    // Overflow sets the status flag.
    flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        overflow |=> overflow_flag_q)
        else $error("overflow flag not set");
    // Counter moves down by one per tick when enabled.
    count_down_a: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && watchdog_on_q && !restart |=> count_q == $past(count_q) - 16'h0001)
        else $error("counter step wrong");

    // Bus, register and output checks.
    // The bus answers every taken request in the next cycle.
    ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_req && ce_i |=> wb_ack_o)
        else $error("request not acknowledged");
    // Acknowledge is a single-cycle pulse.
    ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("acknowledge held too long");
    // Read data stays zero outside an acknowledge.
    read_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside acknowledge");
    // Bits 31 to 6, unused or key bits in every register, always read as zero.
    key_reads_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_dat_o[31:6] == 26'h0)
        else $error("key bits read back");
    // A keyed mode write lands in the four mode fields.
    mode_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_wr |=> {overflow_pin_on_q, overflow_irq_on_q, overflow_reset_on_q, watchdog_on_q}
        == $past(wb_dat_i[3:0]))
        else $error("mode fields not written");
    // A keyed clock write lands in select and preload.
    clock_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        clock_wr |=> {high_preload_value_q, count_clock_select_q} == $past(wb_dat_i[5:0]))
        else $error("clock fields not written");
    // Leaving reset finds the watchdog off and both registers cleared.
    reset_state_a: assert property (@(posedge clk_i)
        $fell(rst_i) |-> {overflow_pin_on_q, overflow_irq_on_q, overflow_reset_on_q, watchdog_on_q} == KWDT_MODE_RESET
        && {high_preload_value_q, count_clock_select_q} == KWDT_CLOCK_RESET)
        else $error("reset state wrong");
    // An armed overflow pulls the pin low in the next cycle.
    pin_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && overflow && overflow_pin_on_q |=> !overflow_pin_n_o)
        else $error("overflow pin not driven");
    // A disabled watchdog never starts a pin pulse.
    pin_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !watchdog_on_q && overflow_pin_n_o |=> overflow_pin_n_o)
        else $error("pin pulse while disabled");
    // A restart clears the overflow flag.
    flag_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        restart |=> !overflow_flag_q)
        else $error("overflow flag kept after restart");
    // A write with a wrong restart key does not reload the counter.
    restart_key_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_go && wb_adr_i == {4'h0, KWDT_OFS_RESTART} && wb_dat_i[15:0] != KWDT_RESTART_KEY
        && !(tick && watchdog_on_q) |=> $stable(count_q))
        else $error("counter reloaded without key");
    // The count holds while the watchdog is off.
    count_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !watchdog_on_q && !restart |=> $stable(count_q))
        else $error("counter moved while disabled");
    // An overflow sets the sticky interrupt status.
    sticky_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        overflow |=> irq_stat_q)
        else $error("sticky status not set");
    // The level interrupt follows status and mask one cycle later.
    irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> irq_o == $past(irq_stat_q && irq_mask_q))
        else $error("interrupt level wrong");
    // At the fastest rate two ticks lie eight cycles apart at least.
    prescale_rate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && count_clock_select_q == 2'h0 |=> !tick [*7])
        else $error("divide by eight too fast");
    // A restart realigns the divider, so no tick follows at once.
    restart_align_a: assert property (@(posedge clk_i) disable iff (rst_i)
        restart |=> !tick)
        else $error("tick right after restart");
    // The internal reset is a single-cycle pulse.
    reset_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
        system_reset_o && ce_i |=> !system_reset_o)
        else $error("internal reset held too long");
    // An internal reset marks a count that went past zero.
    reset_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(system_reset_o) |-> $past(count_q) == 16'h0000 && count_q == 16'hFFFF)
        else $error("internal reset without expiry");
    // A mask write with lane zero takes bit zero.
    mask_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_go && wb_adr_i == KWDT_OFS_IRQ_MASK && wb_sel_i[0] |=> irq_mask_q == $past(wb_dat_i[0]))
        else $error("mask not written");
endmodule
`default_nettype wire

//--- tb/kwdt_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// Stands in for the interrupt controller, the reset logic and the pin load.
module kwdt_far_end (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic irq_i,
    input wire logic sys_rst_i,
    input wire logic pin_n_i,
    output logic [7:0] irq_cnt_o,
    output logic [7:0] rst_cnt_o,
    output logic [7:0] low_cnt_o
);
    // Counts every cycle that a request is seen, so a stretched pulse shows up.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_cnt_o <= 8'h00;
            rst_cnt_o <= 8'h00;
            low_cnt_o <= 8'h00;
        end else begin
            // An unknown on a request counts as asserted, so it cannot hide.
            if (irq_i !== 1'b0) irq_cnt_o <= irq_cnt_o + 8'h01;
            if (sys_rst_i !== 1'b0) rst_cnt_o <= rst_cnt_o + 8'h01;
            if (pin_n_i !== 1'b1) low_cnt_o <= low_cnt_o + 8'h01;
        end
    end
endmodule
`default_nettype wire

//--- tb/keyed_watchdog_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Drives the register bus and watches the overflow outputs of the watchdog.
module keyed_watchdog_timer_tb_top;
    import kwdt_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, q, k;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, irq_pulse, sys_rst, pin_n, irq_o;
    logic [7:0] irq_cnt, rst_cnt, low_cnt;
    int fail_count = 0, total_checks = 0, cycles = 0, n;
    logic ce = 1'b1; // Clock enable; dropped once to show that the block freezes.
    kwdt_top u_kwdt_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .watchdog_irq_pulse_o(irq_pulse), .system_reset_o(sys_rst),
        .overflow_pin_n_o(pin_n), .irq_o(irq_o));
    kwdt_far_end u_kwdt_far_end (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq_pulse), .sys_rst_i(sys_rst),
        .pin_n_i(pin_n), .irq_cnt_o(irq_cnt), .rst_cnt_o(rst_cnt), .low_cnt_o(low_cnt));
    // The clock toggles every half period of 25 ns.
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Compares one result word.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One classic bus cycle, held until ack is sampled high.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int c;
        c = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        do begin
            @(posedge clk_i);
            c++;
        end while (wb_ack_o !== 1'b1 && c < 50);
        if (c >= 50) fail_count++;
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    // Cuts a hang short; the tests need about 85000 cycles at most.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 95000) begin
            fail_count++;
            report_and_stop();
        end
    end
    // Main sequence.
    initial begin
        void'($urandom(32'hDA5D867C));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // Reset values and an unmapped address.
        wb(0, 8'h00, 0, 4'hF); chk(q, 0);
        wb(0, 8'h04, 0, 4'hF); chk(q, 0);
        wb(0, 8'h0C, 0, 4'hF); chk(q, 0);
        wb(0, 8'h20, 0, 4'hF); chk(q, 0);
        // Writes with a wrong key leave the mode and clock registers untouched.
        for (int i = 0; i < 8; i++) begin
            k = $urandom;
            if (k[15:4] == KWDT_MODE_KEY) k[4] = ~k[4];
            wb(1, 8'h00, k, 4'hF); wb(0, 8'h00, 0, 4'hF); chk(q, 0);
            if (k[15:7] == KWDT_CLOCK_KEY) k[7] = ~k[7];
            wb(1, 8'h04, k, 4'hF); wb(0, 8'h04, 0, 4'hF); chk(q, 0);
        end
        // Keyed writes take the fields, every clock select once; keys read back zero.
        for (int i = 0; i < 4; i++) begin
            k = $urandom;
            wb(1, 8'h00, {k[31:16], 16'h2340} | {k[3:1], 1'b0}, 4'hF);
            wb(0, 8'h00, 0, 4'hF); chk(q, {28'h0, k[3:1], 1'b0});
            wb(1, 8'h04, {k[31:16], 16'h3700} | {k[5:2], i[1:0]}, 4'hF);
            wb(0, 8'h04, 0, 4'hF); chk(q, {26'h0, k[5:2], i[1:0]});
        end
        // Enabling sequence with the shortest count and the fastest tap.
        wb(1, 8'h00, 32'h2340, 4'hF);
        wb(1, 8'h04, 32'h3700, 4'hF);
        wb(1, 8'h08, 32'hABCDC071, 4'hF);
        wb(1, 8'h14, 32'h1, 4'hF);
        wb(1, 8'h00, 32'h234F, 4'hF);
        n = 0;
        while (irq_cnt == 8'h00 && n < 40000) begin
            @(posedge clk_i);
            n++;
        end
        // 4096 ticks of eight cycles, give or take the divider phase.
        chk(n >= 32760 && n <= 32800, 1);
        repeat (12) @(posedge clk_i);
        chk(irq_cnt, 1);
        chk(rst_cnt, 1);
        chk(low_cnt, 8);
        wb(0, 8'h0C, 0, 4'hF); chk(q, 1);
        chk(irq_o, 1);
        wb(1, 8'h14, 0, 4'hF); chk(irq_o, 0);
        wb(1, 8'h14, 1, 4'hF); chk(irq_o, 1);
        wb(0, 8'h10, 0, 4'hF); chk(q, 1);
        chk(irq_o, 0);
        // A wrong restart key is ignored; the right one clears the flag.
        k = $urandom;
        if (k[15:0] == KWDT_RESTART_KEY) k[0] = ~k[0];
        wb(1, 8'h08, k, 4'hF); wb(0, 8'h0C, 0, 4'hF); chk(q, 1);
        wb(1, 8'h08, 32'hC071, 4'hF); wb(0, 8'h0C, 0, 4'hF); chk(q, 0);
        // Timely restarts with random spacing keep the armed watchdog quiet.
        for (int i = 0; i < 4; i++) begin
            repeat (1000 + $urandom % 3000) @(posedge clk_i);
            k = $urandom;
            wb(1, 8'h08, {k[31:16], KWDT_RESTART_KEY}, 4'hF);
        end
        // Run close to expiry, then freeze the block; the count must hold still.
        repeat (31000) @(posedge clk_i);
        chk(irq_cnt, 1);
        ce <= 1'b0;
        repeat (3000) @(posedge clk_i);
        ce <= 1'b1;
        @(posedge clk_i);
        wb(0, 8'h0C, 0, 4'hF); chk(q, 0);
        // Disabled with all actions armed and under 1800 cycles left: nothing may happen.
        wb(1, 8'h00, 32'h234E, 4'hF);
        repeat (2000) @(posedge clk_i);
        chk({irq_cnt, rst_cnt, low_cnt}, {8'd1, 8'd1, 8'd8});
        chk(pin_n, 1);
        report_and_stop();
    end
endmodule
`default_nettype wire
